// [logic/tcr_bank_if.sv]
// Register bank contents passed from the serial front end to the field decoder
`timescale 1ns/1ps
interface tcr_bank_if;
	logic [7:0] bank [0:7];
	modport owner (output bank);
	modport user (input bank);
endinterface : tcr_bank_if

// [logic/tcr_field_decode.sv]
// Turns stored register fields into static analog control levels
`timescale 1ns/1ps
module tcr_field_decode import tcr_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	tcr_bank_if.user regs,
	output logic [DEC_W-1:0] controls
);
	logic [14:0] div_val;
	logic [6:0] ref_val;
	logic [1:0] osc_code;
	logic [2:0] band_code;
	logic [1:0] oscillator_output_divider_code;
	logic [1:0] tf_code;
	logic [1:0] in_code;
	logic [1:0] mix_code;
	logic [7:0] ob;
	logic [7:0] op;
	logic [7:0] rp;
	logic [7:0] pd;
	logic [DEC_W-1:0] dec_nxt;

	assign ob = regs.bank[REG_OSC_BAND[2:0]];
	assign op = regs.bank[REG_OVL_PUMP[2:0]];
	assign rp = regs.bank[REG_RF_PATH[2:0]];
	assign pd = regs.bank[REG_POWER_DOWN[2:0]];
	assign div_val = {regs.bank[REG_DIV_HIGH[2:0]][6:0], regs.bank[REG_DIV_LOW[2:0]]};
	assign ref_val = regs.bank[REG_REF_DIV[2:0]][6:0];
	assign osc_code = ob[OSC_SEL_LSB +: 2];
	assign band_code = ob[SUB_BAND_LSB +: 3];
	assign oscillator_output_divider_code = ob[OUT_DIV_LSB +: 2];
	assign tf_code = op[BAND_LSB +: 2];
	assign in_code = rp[INPUT_LSB +: 2];
	assign mix_code = pd[MIX_PD_LSB +: 2];

	// Order matches the unpacking in the top module
	assign dec_nxt = {
		div_val,
		(div_val >= DIV_MIN) && (div_val <= DIV_MAX),
		ref_val,
		(ref_val >= REF_MIN) && (ref_val <= REF_MAX),
		osc_code == 2'h3, osc_code == 2'h2, osc_code == 2'h1,
		8'(8'h01 << band_code),
		ob[LOCK_DET_BIT],
		6'(6'h04 << oscillator_output_divider_code),
		op[OVL_LSB +: 3],
		op[PUMP_LSB +: 2],
		tf_code == 2'h2, tf_code == 2'h1, tf_code == 2'h0,
		tf_code == 2'h3,
		rp[RF_PD_BIT],
		rp[IFAMP_PD_BIT],
		in_code == 2'h2, ~in_code[1], in_code == 2'h0,
		in_code == 2'h3,
		mix_code == 2'h3,
		^mix_code,
		pd[IF_PD_BIT],
		pd[DET_PD_BIT],
		pd[SYN_PD_BIT],
		regs.bank[REG_SERIES_CAP[2:0]]
	};

	// Registered so analog controls never see decode glitches
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			controls <= '0;
		end else begin
			controls <= dec_nxt;
		end
	end
endmodule : tcr_field_decode

// [logic/tcr_pin_sync.sv]
// Three-stage pin synchroniser; a change is taken once stages two and three agree
`timescale 1ns/1ps
module tcr_pin_sync import tcr_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] raw,
	output logic [3:0] clean
);
	logic [3:0] meta_r;
	logic [3:0] stage2_r;
	logic [3:0] stage3_r;
	logic [3:0] clean_nxt;

	// Keep old value wherever the two late stages disagree
	assign clean_nxt = (stage2_r & stage3_r) | (clean & (stage2_r | stage3_r));

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_r <= SYNC_IDLE;
			stage2_r <= SYNC_IDLE;
			stage3_r <= SYNC_IDLE;
			clean <= SYNC_IDLE;
		end else begin
			meta_r <= raw;
			stage2_r <= meta_r;
			stage3_r <= stage2_r;
			clean <= clean_nxt;
		end
	end
endmodule : tcr_pin_sync

// [logic/tcr_pkg.sv]
// Shared constants, reset values and types of the tuner control register bank
package tcr_pkg;

	// Register offsets as seen through the two-wire pointer
	localparam logic [3:0] REG_DIV_HIGH = 4'h0;
	localparam logic [3:0] REG_DIV_LOW = 4'h1;
	localparam logic [3:0] REG_REF_DIV = 4'h2;
	localparam logic [3:0] REG_OSC_BAND = 4'h3;
	localparam logic [3:0] REG_OVL_PUMP = 4'h4;
	localparam logic [3:0] REG_RF_PATH = 4'h5;
	localparam logic [3:0] REG_POWER_DOWN = 4'h6;
	localparam logic [3:0] REG_SERIES_CAP = 4'h7;
	localparam logic [3:0] REG_COUNT = 4'h8;

	// Reset values (recommended settings)
	localparam logic [7:0] RST_DIV_HIGH = 8'h12;
	localparam logic [7:0] RST_DIV_LOW = 8'hAB;
	localparam logic [7:0] RST_REF_DIV = 8'h10;
	localparam logic [7:0] RST_OSC_BAND = 8'hBE;
	localparam logic [7:0] RST_OVL_PUMP = 8'h00;
	localparam logic [7:0] RST_RF_PATH = 8'h01;
	localparam logic [7:0] RST_POWER_DOWN = 8'h00;
	localparam logic [7:0] RST_SERIES_CAP = 8'h0F;

	// Writable bits; reserved bits are stored as zero
	localparam logic [7:0] MASK_DIV_HIGH = 8'h7F;
	localparam logic [7:0] MASK_REF_DIV = 8'h7F;
	localparam logic [7:0] MASK_OVL_PUMP = 8'h7F;
	localparam logic [7:0] MASK_RF_PATH = 8'h0F;
	localparam logic [7:0] MASK_POWER_DOWN = 8'hF8;
	localparam logic [7:0] MASK_FULL = 8'hFF;

	// Field positions
	localparam int OSC_SEL_LSB = 6;
	localparam int SUB_BAND_LSB = 3;
	localparam int LOCK_DET_BIT = 2;
	localparam int OUT_DIV_LSB = 0;
	localparam int OVL_LSB = 4;
	localparam int PUMP_LSB = 2;
	localparam int BAND_LSB = 0;
	localparam int RF_PD_BIT = 3;
	localparam int IFAMP_PD_BIT = 2;
	localparam int INPUT_LSB = 0;
	localparam int MIX_PD_LSB = 6;
	localparam int IF_PD_BIT = 5;
	localparam int DET_PD_BIT = 4;
	localparam int SYN_PD_BIT = 3;

	// Programmable ranges
	localparam logic [14:0] DIV_MIN = 15'h0100;
	localparam logic [14:0] DIV_MAX = 15'h7FFF;
	localparam logic [6:0] REF_MIN = 7'h10;
	localparam logic [6:0] REF_MAX = 7'h7F;

	localparam logic [4:0] SLAVE_ADDR_HI = 5'h18;
	localparam logic [3:0] SYNC_IDLE = 4'hF;
	localparam int DEC_W = 70;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_PTR = 3'h2,
		ST_WDATA = 3'h3,
		ST_ACK = 3'h4,
		ST_RDATA = 3'h5,
		ST_RACK = 3'h6
	} tcr_state_t;

	function automatic logic [7:0] tcr_rst_val(input logic [2:0] idx);
		case (idx)
			3'h0: tcr_rst_val = RST_DIV_HIGH;
			3'h1: tcr_rst_val = RST_DIV_LOW;
			3'h2: tcr_rst_val = RST_REF_DIV;
			3'h3: tcr_rst_val = RST_OSC_BAND;
			3'h4: tcr_rst_val = RST_OVL_PUMP;
			3'h5: tcr_rst_val = RST_RF_PATH;
			3'h6: tcr_rst_val = RST_POWER_DOWN;
			default: tcr_rst_val = RST_SERIES_CAP;
		endcase
	endfunction : tcr_rst_val

	function automatic logic [7:0] tcr_wr_mask(input logic [2:0] idx);
		case (idx)
			3'h0: tcr_wr_mask = MASK_DIV_HIGH;
			3'h2: tcr_wr_mask = MASK_REF_DIV;
			3'h4: tcr_wr_mask = MASK_OVL_PUMP;
			3'h5: tcr_wr_mask = MASK_RF_PATH;
			3'h6: tcr_wr_mask = MASK_POWER_DOWN;
			default: tcr_wr_mask = MASK_FULL;
		endcase
	endfunction : tcr_wr_mask

endpackage : tcr_pkg

// [logic/tcr_top.sv]
// Tuner control register bank with its two-wire serial slave
//
// Behaviour
// - Divider low byte holds divider bits 7..0; valid divider range 256 to 32767.
// - Reference divider holds seven bits in 6..0, valid 16 to 127, bit 7 reserved.
// - Oscillator select 00 powers all down; 01,10,11 enable oscillator one, two, three.
// - Sub-band bits 5..3 pick sub-band zero to seven by binary value.
// - Oscillator register bit 2 set enables lock detection, clear disables it.
// - Output divider bits 1..0 give ratio 4, 8, 16 or 32.
// - Pump bits 3..2 select 0.5, 1, 1.5 or 2 mA.
// - Filter band 00 low VHF, 01 high VHF, 10 UHF, 11 factory.
// - Control bit 3 set disables RF circuitry.
// - Control bit 2 set disables IF gain amplifier.
// - Input 00 VHF with lowpass, 01 VHF without, 10 UHF, 11 factory.
// - Mixer bits 7..6: 00 enabled, 11 disabled, 01 and 10 factory.
// - Power-down bit 5 set disables the IF section.
// - Power-down bit 4 set disables the overload power detector.
// - Power-down bit 3 set powers down the synthesizer.
// - Series capacitor register holds eight-bit tracking filter series code.
// - Divider high register holds divider bits 14..8 in bits 6..0.
`timescale 1ns/1ps
module tcr_top import tcr_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_drive_n,
	input wire logic addr_pin1,
	input wire logic addr_pin2,
	output logic [14:0] synth_divider,
	output logic divider_in_range,
	output logic [6:0] ref_divider,
	output logic ref_in_range,
	output logic [2:0] osc_enable,
	output logic [7:0] sub_band,
	output logic lock_detect_enable,
	output logic [5:0] oscillator_output_divider,
	output logic [2:0] overload_threshold,
	output logic [1:0] pump_current_select,
	output logic uhf_band,
	output logic high_vhf_band,
	output logic low_vhf_band,
	output logic filter_factory_mode,
	output logic rf_power_down,
	output logic if_amplifier_power_down,
	output logic high_band_rf_input,
	output logic low_band_rf_input,
	output logic lowpass_enable,
	output logic input_factory_mode,
	output logic mixer_power_down,
	output logic mixer_factory_mode,
	output logic if_section_power_down,
	output logic detector_power_down,
	output logic synthesizer_power_down,
	output logic [7:0] series_capacitor_code
);
	tcr_bank_if bank_ifc ();

	logic [3:0] pins_clean;
	logic scl_s;
	logic sda_s;
	logic addr1_s;
	logic addr2_s;
	logic scl_q_r;
	logic sda_q_r;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	tcr_state_t state_r;
	tcr_state_t state_nxt;
	tcr_state_t ack_next_r;
	tcr_state_t ack_next_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic [3:0] ptr_r;
	logic [3:0] ptr_nxt;
	logic drive_r;
	logic drive_nxt;
	logic mack_r;
	logic mack_nxt;
	logic wr_en;

	logic addr_match;
	logic byte_done;
	logic ptr_hit;
	logic [7:0] rd_byte;
	logic [DEC_W-1:0] controls;

	// All four pins cross from the board, so they share one synchroniser.
	// The price is about four clocks of latency on every bus edge, which
	// is why the host must hold each SCL phase for at least five clocks.
	tcr_pin_sync u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.raw({addr_pin2, addr_pin1, sda_in, scl_in}),
		.clean(pins_clean)
	);

	assign scl_s = pins_clean[0];
	assign sda_s = pins_clean[1];
	assign addr1_s = pins_clean[2];
	assign addr2_s = pins_clean[3];

	// Bus conditions seen on the cleaned lines
	assign scl_rise = scl_s & ~scl_q_r;
	assign scl_fall = ~scl_s & scl_q_r;
	assign start_cond = scl_s & scl_q_r & sda_q_r & ~sda_s;
	assign stop_cond = scl_s & scl_q_r & ~sda_q_r & sda_s;

	assign addr_match = shift_r[7:1] == {SLAVE_ADDR_HI, addr2_s, addr1_s};
	assign byte_done = scl_fall && (cnt_r == 4'h8);
	assign ptr_hit = ptr_r < REG_COUNT;
	// Offsets beyond this bank read as zero and ignore writes
	assign rd_byte = ptr_hit ? bank_ifc.bank[ptr_r[2:0]] : 8'h00;

	// Byte engine: bits are taken on SCL rise, the line is changed only
	// after SCL fall, so the data never moves while the clock is high.
	// START and STOP override every state so a confused host can recover.
	always_comb begin
		state_nxt = state_r;
		ack_next_nxt = ack_next_r;
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		ptr_nxt = ptr_r;
		drive_nxt = drive_r;
		mack_nxt = mack_r;
		wr_en = 1'b0;
		if (start_cond) begin
			// Repeated start is legal at any point and resynchronises the engine
			state_nxt = ST_ADDR;
			cnt_nxt = 4'h0;
			drive_nxt = 1'b0;
		end else if (stop_cond) begin
			state_nxt = ST_IDLE;
			drive_nxt = 1'b0;
		end else begin
			case (state_r)
				ST_ADDR, ST_PTR, ST_WDATA: begin
					if (scl_rise) begin
						shift_nxt = {shift_r[6:0], sda_s};
						cnt_nxt = cnt_r + 4'h1;
					end else if (byte_done) begin
						cnt_nxt = 4'h0;
						state_nxt = ST_ACK;
						drive_nxt = 1'b1;
						if (state_r == ST_ADDR) begin
							if (addr_match) begin
								ack_next_nxt = shift_r[0] ? ST_RDATA : ST_PTR;
							end else begin
								state_nxt = ST_IDLE;
								drive_nxt = 1'b0;
							end
						end else if (state_r == ST_PTR) begin
							ptr_nxt = shift_r[3:0];
							ack_next_nxt = ST_WDATA;
						end else begin
							wr_en = ptr_hit;
							ptr_nxt = ptr_r + 4'h1;
							ack_next_nxt = ST_WDATA;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						state_nxt = ack_next_r;
						cnt_nxt = 4'h0;
						if (ack_next_r == ST_RDATA) begin
							shift_nxt = rd_byte;
							drive_nxt = ~rd_byte[7];
						end else begin
							drive_nxt = 1'b0;
						end
					end
				end
				ST_RDATA: begin
					if (scl_rise) begin
						cnt_nxt = cnt_r + 4'h1;
					end else if (byte_done) begin
						drive_nxt = 1'b0;
						ptr_nxt = ptr_r + 4'h1;
						state_nxt = ST_RACK;
					end else if (scl_fall) begin
						shift_nxt = {shift_r[6:0], 1'b0};
						drive_nxt = ~shift_r[6];
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						mack_nxt = ~sda_s;
					end else if (scl_fall) begin
						cnt_nxt = 4'h0;
						if (mack_r) begin
							state_nxt = ST_RDATA;
							shift_nxt = rd_byte;
							drive_nxt = ~rd_byte[7];
						end else begin
							state_nxt = ST_IDLE;
						end
					end
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			state_r <= ST_IDLE;
			ack_next_r <= ST_IDLE;
			cnt_r <= 4'h0;
			shift_r <= 8'h00;
			ptr_r <= 4'h0;
			drive_r <= 1'b0;
			mack_r <= 1'b0;
		end else begin
			scl_q_r <= scl_s;
			sda_q_r <= sda_s;
			state_r <= state_nxt;
			ack_next_r <= ack_next_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			ptr_r <= ptr_nxt;
			drive_r <= drive_nxt;
			mack_r <= mack_nxt;
		end
	end

	// Reserved bits are forced to zero so read-back matches what the part honours
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < 8; i++) begin
				bank_ifc.bank[i] <= tcr_rst_val(3'(i));
			end
		end else if (wr_en) begin
			bank_ifc.bank[ptr_r[2:0]] <= shift_r & tcr_wr_mask(ptr_r[2:0]);
		end
	end

	// Open-drain data line: only ever pulled low
	assign sda_out = 1'b0;
	assign sda_drive_n = ~drive_r;

	// Controls follow the bank one clock later; no shadowing of the divider
	// halves, so a two-byte divider change passes through one mixed value.
	tcr_field_decode u_decode (
		.clk(clk),
		.sys_rst(sys_rst),
		.regs(bank_ifc.user),
		.controls(controls)
	);

	assign {
		synth_divider,
		divider_in_range,
		ref_divider,
		ref_in_range,
		osc_enable,
		sub_band,
		lock_detect_enable,
		oscillator_output_divider,
		overload_threshold,
		pump_current_select,
		uhf_band,
		high_vhf_band,
		low_vhf_band,
		filter_factory_mode,
		rf_power_down,
		if_amplifier_power_down,
		high_band_rf_input,
		low_band_rf_input,
		lowpass_enable,
		input_factory_mode,
		mixer_power_down,
		mixer_factory_mode,
		if_section_power_down,
		detector_power_down,
		synthesizer_power_down,
		series_capacitor_code
	} = controls;

endmodule : tcr_top

// [verification/tcr_host.sv]
// Two-wire bus master standing in for the tuner's host controller
`timescale 1ns/1ps
module tcr_host (
	input wire logic clk,
	input wire logic sda_w,
	output logic scl,
	output logic sda_m
);
	// Phases of 2*H cycles keep above the 5-cycle minimum of the slave
	localparam int H = 3;
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask : hold
	task automatic bit_io(input logic b, output logic r);
		scl <= 1'b0;
		hold(H);
		sda_m <= b;
		hold(H);
		scl <= 1'b1;
		hold(2 * H);
		r = sda_w;
	endtask : bit_io
	task automatic start_c;
		logic d;
		bit_io(1'b1, d);
		sda_m <= 1'b0;
		hold(2 * H);
	endtask : start_c
	task automatic stop_c;
		logic d;
		bit_io(1'b0, d);
		sda_m <= 1'b1;
		hold(2 * H);
	endtask : stop_c
	task automatic byte_io(input logic [7:0] d, input logic ai, output logic [7:0] q,
		output logic a);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(ai, a);
	endtask : byte_io
endmodule : tcr_host

// [verification/tcr_top_chk.sv]
// Port-level assertions for the tuner control register bank
`timescale 1ns/1ps
module tcr_top_chk import tcr_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic [14:0] synth_divider,
	input wire logic divider_in_range,
	input wire logic [6:0] ref_divider,
	input wire logic ref_in_range,
	input wire logic [2:0] osc_enable,
	input wire logic [7:0] sub_band,
	input wire logic [5:0] oscillator_output_divider,
	input wire logic uhf_band,
	input wire logic high_vhf_band,
	input wire logic low_vhf_band,
	input wire logic filter_factory_mode,
	input wire logic mixer_power_down,
	input wire logic mixer_factory_mode,
	input wire logic [7:0] series_capacitor_code
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// Controls read zero in reset, so the edge that loads them is skipped
	property p_div_range;
		divider_in_range == (synth_divider >= DIV_MIN);
	endproperty
	a_div_range: assert property (p_div_range) else $error("divider range flag wrong");
	property p_ref_range;
		ref_in_range == (ref_divider >= REF_MIN);
	endproperty
	a_ref_range: assert property (p_ref_range) else $error("reference range flag wrong");
	property p_osc;
		$onehot0(osc_enable);
	endproperty
	a_osc: assert property (p_osc) else $error("more than one oscillator on");
	property p_sub;
		!$past(sys_rst) |-> $onehot(sub_band);
	endproperty
	a_sub: assert property (p_sub) else $error("sub-band not one-hot");
	property p_out_div;
		!$past(sys_rst) |-> oscillator_output_divider inside {6'h04, 6'h08, 6'h10, 6'h20};
	endproperty
	a_out_div: assert property (p_out_div) else $error("bad output divider ratio");
	property p_band;
		!$past(sys_rst) |-> $onehot({uhf_band, high_vhf_band, low_vhf_band, filter_factory_mode});
	endproperty
	a_band: assert property (p_band) else $error("filter band not one-hot");
	property p_mixer;
		!(mixer_power_down && mixer_factory_mode);
	endproperty
	a_mixer: assert property (p_mixer) else $error("mixer off and factory at once");
	// Writes land shortly after an SCL fall, never late in a long high phase
	property p_static;
		(!$past(sys_rst) && scl_in)[*5] |-> $stable(synth_divider) && $stable(series_capacitor_code);
	endproperty
	a_static: assert property (p_static) else $error("control moved while bus quiet");
	c_osc3: cover property (osc_enable == 3'h4);
	c_mix: cover property (mixer_power_down);
	c_uhf: cover property (uhf_band);
endmodule : tcr_top_chk

bind tcr_top tcr_top_chk tcr_top_chk_i (.*);

// [verification/tcr_top_test.sv]
// Self-checking bench for the tuner control register bank
`timescale 1ns/1ps
module tcr_top_test import tcr_pkg::*; ;
	logic clk, sys_rst, scl, sda_m, sda_out, sda_drive_n;
	logic divider_in_range, ref_in_range, lock_detect_enable, uhf_band, high_vhf_band;
	logic low_vhf_band, filter_factory_mode, rf_power_down, if_amplifier_power_down;
	logic high_band_rf_input, low_band_rf_input, lowpass_enable, input_factory_mode;
	logic mixer_power_down, mixer_factory_mode, if_section_power_down, detector_power_down;
	logic synthesizer_power_down;
	logic [14:0] synth_divider;
	logic [6:0] ref_divider;
	logic [2:0] osc_enable, overload_threshold;
	logic [7:0] sub_band, series_capacitor_code;
	logic [5:0] oscillator_output_divider;
	logic [1:0] pump_current_select;
	logic [7:0] m [0:7];
	logic [7:0] rv [0:7] = '{RST_DIV_HIGH, RST_DIV_LOW, RST_REF_DIV, RST_OSC_BAND,
		RST_OVL_PUMP, RST_RF_PATH, RST_POWER_DOWN, RST_SERIES_CAP};
	logic [31:0] seed = 32'h000138B1;
	int miscompares = 0;
	int n_tests = 0;
	int cyc = 0;
	// Pull-up on the wire: a low from the host or a low enable from the slave pulls it down
	wire sda_w = sda_m && (sda_drive_n !== 1'b0);

	tcr_top tcr_top_i (.*, .scl_in(scl), .sda_in(sda_w), .addr_pin1(1'b0), .addr_pin2(1'b0));
	tcr_host tcr_host_i (.clk, .sda_w, .scl, .sda_m);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			$display("BAD %0t run did not finish", $time);
			finish_test();
		end
	end
	function automatic logic [7:0] rnd8();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd8
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic put(input logic [7:0] d, input logic ea);
		logic [7:0] q;
		logic a;
		tcr_host_i.byte_io(d, 1'b1, q, a);
		chk(16'(a), 16'(ea));
	endtask : put
	task automatic wr(input logic [7:0] p, input int n);
		tcr_host_i.start_c();
		put(8'hC0, 1'b0);
		put(p, 1'b0);
		for (int i = 0; i < n; i++) put((p < 8) ? m[p + i] : 8'h5A, 1'b0);
		tcr_host_i.stop_c();
	endtask : wr
	task automatic rd(input logic [7:0] p, input int n);
		logic [7:0] q;
		logic a;
		tcr_host_i.start_c();
		put(8'hC0, 1'b0);
		put(p, 1'b0);
		tcr_host_i.start_c();
		put(8'hC1, 1'b0);
		for (int i = 0; i < n; i++) begin
			tcr_host_i.byte_io(8'hFF, i == n - 1, q, a);
			chk(16'(q), (p + i < 8) ? 16'(m[p + i]) : 16'h0000);
		end
		tcr_host_i.stop_c();
	endtask : rd
	task automatic ctl;
		logic [14:0] n;
		logic [1:0] o, t, s, x;
		@(negedge clk);
		n = {m[0][6:0], m[1]};
		o = m[3][7:6];
		t = m[4][1:0];
		s = m[5][1:0];
		x = m[6][7:6];
		chk(16'({divider_in_range, synth_divider}), 16'({n >= 15'h0100, n}));
		chk(16'({ref_in_range, ref_divider}), 16'({m[2][6:0] >= 7'h10, m[2][6:0]}));
		chk(16'(osc_enable), (o == 2'h0) ? 16'h0000 : 16'h0001 << (o - 2'h1));
		chk(16'(sub_band), 16'h0001 << m[3][5:3]);
		chk(16'(lock_detect_enable), 16'(m[3][2]));
		chk(16'(oscillator_output_divider), 16'h0004 << m[3][1:0]);
		chk(16'({overload_threshold, pump_current_select}), 16'(m[4][6:2]));
		chk(16'({uhf_band, high_vhf_band, low_vhf_band, filter_factory_mode}),
			16'({t == 2'h2, t == 2'h1, t == 2'h0, t == 2'h3}));
		chk(16'({rf_power_down, if_amplifier_power_down}), 16'(m[5][3:2]));
		chk(16'({high_band_rf_input, low_band_rf_input, lowpass_enable, input_factory_mode}),
			16'({s == 2'h2, s < 2'h2, s == 2'h0, s == 2'h3}));
		chk(16'({mixer_power_down, mixer_factory_mode}), 16'({x == 2'h3, ^x}));
		chk(16'({if_section_power_down, detector_power_down, synthesizer_power_down}),
			16'(m[6][5:3]));
		chk(16'(series_capacitor_code), 16'(m[7]));
		chk(16'({sda_out, sda_drive_n}), 16'h0001);
	endtask : ctl
	task automatic do_reset;
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
	endtask : do_reset
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : finish_test

	initial begin
		sys_rst = 1'b1;
		do_reset();
		repeat (1000) @(posedge clk);
		m = rv;
		ctl();
		rd(8'h00, 8);
		for (int r = 0; r < 8; r++) begin
			foreach (m[i]) m[i] = rnd8();
			m[0][7] = 1'b0;
			m[2][7] = 1'b0;
			m[3] = {r[1:0], r[2:0], m[3][2], r[1:0]};
			m[4] = {1'b0, m[4][6:2], r[1:0]};
			m[5] = {4'h0, m[5][3:2], r[1:0]};
			m[6] = {r[1:0], m[6][5:3], 3'h0};
			if (r == 0) {m[0], m[1], m[2]} = 24'h00FF0F;
			if (r == 1) {m[0], m[1], m[2]} = 24'h010010;
			if (r == 2) {m[0], m[1], m[2]} = 24'h7FFF7F;
			wr(8'h00, 8);
			ctl();
			rd(8'(r), 8 - r);
		end
		// Writes past the bank are taken but must leave every control alone
		wr(8'h09, 1);
		rd(8'h09, 1);
		tcr_host_i.start_c();
		put(8'hC2, 1'b1);
		tcr_host_i.stop_c();
		ctl();
		do_reset();
		repeat (2) @(posedge clk);
		m = rv;
		ctl();
		finish_test();
	end
endmodule : tcr_top_test
